// file: src/rms_energy_correction_datapath.sv
// Rms, offset correction, apparent scaling, line-cycle energy and phase trim.
// Assumes sample inputs synchronous to sys_clk, taken every eighth clock, and
// a single AHB-Lite master with whole-word single transfers.
`timescale 1ns/1ps
`include "rms_energy_cfg.svh"
module rms_energy_correction_datapath
  import rms_energy_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Channel samples
  input wire sample_type vSample,
  input wire sample_type iSample,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Open-drain interrupt pin
  output logic irqOut,
  output logic irqOe
);
  // ----------------------------------------
  // Reset release and sample tick
  // ----------------------------------------
  logic [1:0] rstPipe;
  wire rstSyncN = rstPipe[1];
  logic [2:0] divCnt;
  logic tickD1, tickD2, resultStb;
  wire tick = (divCnt == `TICK_LAST);

  // Release through two flops so logic leaves reset on one edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  // Eight clocks per sample step sets the phase trim resolution
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      divCnt <= 3'h0;
      tickD1 <= 1'b0;
      tickD2 <= 1'b0;
      resultStb <= 1'b0;
    end else begin
      divCnt <= divCnt + 3'h1;
      tickD1 <= tick;
      tickD2 <= tickD1;
      resultStb <= tickD2;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [2:0] ctrl;
  logic signed [11:0] vrmsOffset, irmsOffset, appGain;
  logic [7:0] appDivider;
  logic [15:0] halfCycleCount;
  logic signed [5:0] phaseAdjust;
  logic [15:0] voltageRms, currentRms;
  logic signed [31:0] lineActive, lineReactive;
  logic [31:0] lineApparent;
  logic [1:0] status;
  logic wrPend;
  logic [7:0] wrAddr;

  // ----------------------------------------
  // Phase trim and delay lines
  // ----------------------------------------
  sample_type vDel, iDel;
  wire [5:0] vTap = phaseAdjust[5] ? 6'h00 : phaseAdjust;

  // voltage tap versus fixed current tap
  sample_delay_ram vDelay (
    .sys_clk(sys_clk),
    .rstN(rstSyncN),
    .wrEn(tick),
    .wrData(vSample),
    .tap(vTap),
    .rdData(vDel)
  );
  sample_delay_ram iDelay (
    .sys_clk(sys_clk),
    .rstN(rstSyncN),
    .wrEn(tick),
    .wrData(iSample),
    .tap(`CURRENT_TAP),
    .rdData(iDel)
  );

  // ----------------------------------------
  // Rms path
  // ----------------------------------------
  function automatic logic [15:0] isqrt(input logic [31:0] x);
    logic [15:0] root;
    logic [15:0] trial;
    root = 16'h0000;
    for (int b = 15; b >= 0; b--) begin
      trial = root | (16'h0001 << b);
      if ({16'h0000, trial} * {16'h0000, trial} <= x) begin
        root = trial;
      end
    end
    return root;
  endfunction

  logic [31:0] lpfV, lpfI;
  wire signed [31:0] vSq = vDel * vDel;
  wire signed [31:0] iSq = iDel * iDel;
  wire signed [32:0] diffV = $signed({1'b0, vSq}) - $signed({1'b0, lpfV});
  wire signed [32:0] diffI = $signed({1'b0, iSq}) - $signed({1'b0, lpfI});
  wire [31:0] next_lpfV = lpfV + 32'(diffV >>> `SQ_LPF_SHIFT);
  wire [31:0] next_lpfI = lpfI + 32'(diffI >>> `SQ_LPF_SHIFT);
  wire [15:0] vrmsRaw = isqrt(lpfV);
  // offset scaled by 32768 before root
  wire signed [33:0] irmsSqSum = $signed({2'b00, lpfI}) +
    ($signed(34'(irmsOffset)) <<< `CURRENT_RMS_OS_SHIFT);
  wire [31:0] irmsSqCorr = irmsSqSum[33] ? 32'h00000000 : irmsSqSum[31:0];
  wire signed [17:0] vrmsSum = $signed({2'b00, vrmsRaw}) + $signed(18'(vrmsOffset));
  wire [15:0] vrmsCorr = vrmsSum[17] ? 16'h0000 : vrmsSum[15:0];

  // Squared filters advance on delayed samples, roots one clock later
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lpfV <= 32'h00000000;
      lpfI <= 32'h00000000;
      voltageRms <= 16'h0000;
      currentRms <= 16'h0000;
    end else begin
      if (tickD1) begin
        lpfV <= next_lpfV;
        lpfI <= next_lpfI;
      end
      if (tickD2) begin
        voltageRms <= vrmsCorr;
        currentRms <= isqrt(irmsSqCorr);
      end
    end
  end

  // ----------------------------------------
  // Reactive filter and instantaneous powers
  // ----------------------------------------
  logic signed [35:0] varAcc;
  // one-pole low-pass near 2 Hz at 3.125 MHz steps
  wire signed [35:0] next_varAcc = varAcc + 36'(iDel) - (varAcc >>> `VAR_LPF_SHIFT);

  // Filter state steps once per sample, in step with the squared filters
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      varAcc <= 36'sh000000000;
    end else if (tickD1) begin
      varAcc <= next_varAcc;
    end
  end
  wire signed [15:0] iLow = varAcc[33:18];
  wire signed [31:0] pAct = vDel * iDel;
  wire signed [31:0] pReact = vDel * iLow;
  wire [31:0] pApp = voltageRms * currentRms;

  // ----------------------------------------
  // Zero crossing and line accumulation
  // ----------------------------------------
  line_state_type lineState;
  logic prevSign;
  logic [15:0] halfCnt;
  logic signed [31:0] accAct, accReact;
  logic [31:0] accApp;
  wire zxEvent = tickD1 && (vDel[15] != prevSign);
  wire lineEn = ctrl[`CTRL_LINE_EN];
  wire lastHalf = (halfCnt + 16'h0001) >= halfCycleCount;
  wire lineDone = (lineState == LINE_RUN) && zxEvent && lastHalf;
  // divide by divider, scale by one plus gain/4096
  wire [7:0] divisor = (appDivider == 8'h00) ? 8'h01 : appDivider;
  wire [31:0] appQuot = accApp / {24'h000000, divisor};
  wire [12:0] appFactor = `GAIN_ONE + 13'(appGain);
  wire [44:0] appProd = {13'h0000, appQuot} * {32'h00000000, appFactor};
  wire [31:0] appScaled = appProd[43:12];

  // Half cycles counted between voltage sign changes
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      prevSign <= 1'b0;
      lineState <= LINE_IDLE;
      halfCnt <= 16'h0000;
    end else begin
      if (tickD1) begin
        prevSign <= vDel[15];
      end
      unique case (lineState)
        LINE_IDLE: begin
          halfCnt <= 16'h0000;
          if (lineEn && zxEvent) begin
            lineState <= LINE_RUN;
          end
        end
        LINE_RUN: begin
          if (!lineEn) begin
            lineState <= LINE_IDLE;
          end else if (zxEvent) begin
            halfCnt <= lastHalf ? 16'h0000 : halfCnt + 16'h0001;
          end
        end
      endcase
    end
  end

  // accumulate, then latch all three together
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      accAct <= 32'sh00000000;
      accReact <= 32'sh00000000;
      accApp <= 32'h00000000;
      lineActive <= 32'sh00000000;
      lineReactive <= 32'sh00000000;
      lineApparent <= 32'h00000000;
    end else if (lineState == LINE_IDLE || lineDone) begin
      accAct <= 32'sh00000000;
      accReact <= 32'sh00000000;
      accApp <= 32'h00000000;
      if (lineDone) begin
        lineActive <= accAct;
        lineReactive <= accReact;
        lineApparent <= appScaled;
      end
    end else if (tickD1) begin
      // Top halves keep their sign so negative power subtracts
      accAct <= accAct + 32'($signed(pAct[31:16]));
      accReact <= accReact + 32'($signed(pReact[31:16]));
      accApp <= accApp + {16'h0000, pApp[31:16]};
    end
  end

  // Reactive reading stays attenuated as 1/f; scaling is left to software

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  wire addrPhase = hsel && htrans[1] && hready;
  wire [7:0] rdOfs = haddr[7:0];
  wire [31:0] rdMux =
    (rdOfs == `OFS_CTRL) ? {29'h0, ctrl} :
    (rdOfs == `OFS_VOLTAGE_RMS_OS) ? {20'h0, vrmsOffset} :
    (rdOfs == `OFS_CURRENT_RMS_OS) ? {20'h0, irmsOffset} :
    (rdOfs == `OFS_APP_GAIN) ? {20'h0, appGain} :
    (rdOfs == `OFS_APP_DIV) ? {24'h0, appDivider} :
    (rdOfs == `OFS_HALF_CYC) ? {16'h0, halfCycleCount} :
    (rdOfs == `OFS_PHASE) ? {26'h0, phaseAdjust} :
    (rdOfs == `OFS_VOLTAGE_RMS) ? {16'h0, voltageRms} :
    (rdOfs == `OFS_CURRENT_RMS) ? {16'h0, currentRms} :
    (rdOfs == `OFS_LINE_ACT) ? lineActive :
    (rdOfs == `OFS_LINE_APP) ? lineApparent :
    (rdOfs == `OFS_LINE_REACT) ? lineReactive :
    (rdOfs == `OFS_STATUS) ? {30'h0, status} : 32'h00000000;
  wire wrSel = wrPend;
  wire wrStatus = wrSel && wrAddr == `OFS_STATUS;
  wire [1:0] statusSet = {zxEvent, lineDone};
  wire [1:0] statusClr = wrStatus ? hwdata[1:0] : 2'b00;

  // Zero wait states: read data is registered in the address phase
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr <= rdOfs;
      end
      if (addrPhase && !hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  // Data-phase writes; result registers ignore writes
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ctrl <= 3'h0;
      vrmsOffset <= 12'sh000;
      irmsOffset <= 12'sh000;
      appGain <= 12'sh000;
      appDivider <= `APP_DIV_RST;
      halfCycleCount <= `HALF_CYC_RST;
      phaseAdjust <= `PHASE_RST;
    end else if (wrSel) begin
      if (wrAddr == `OFS_CTRL) ctrl <= hwdata[2:0];
      if (wrAddr == `OFS_VOLTAGE_RMS_OS) vrmsOffset <= hwdata[11:0];
      if (wrAddr == `OFS_CURRENT_RMS_OS) irmsOffset <= hwdata[11:0];
      if (wrAddr == `OFS_APP_GAIN) appGain <= hwdata[11:0];
      if (wrAddr == `OFS_APP_DIV) appDivider <= hwdata[7:0];
      if (wrAddr == `OFS_HALF_CYC) halfCycleCount <= hwdata[15:0];
      if (wrAddr == `OFS_PHASE) phaseAdjust <= hwdata[5:0];
    end
  end

  // ----------------------------------------
  // Status and interrupt pin
  // ----------------------------------------
  // sticky flags, set beats write-one clear
  wire irqWant = (status[`ST_ZX] && ctrl[`CTRL_ZX_IRQ]) ||
    (status[`ST_LINE] && ctrl[`CTRL_LINE_IRQ]);
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      status <= 2'b00;
      irqOut <= 1'b0;
      irqOe <= 1'b0;
    end else begin
      status <= (status & ~statusClr) | statusSet;
      irqOut <= 1'b0;
      irqOe <= irqWant;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSyncN);

  property p_sqrtBound;
    resultStb |-> ({16'h0, voltageRms} * {16'h0, voltageRms}) <=
      $past(lpfV) + 32'h00000FFF + ({20'h0, $past(vrmsOffset)} << 17);
  endproperty
  a_sqrtBound: assert property (p_sqrtBound) else $error("rms root too large");

  property p_vrmsOffset;
    resultStb |-> voltageRms == $past(vrmsCorr) &&
      ($past(vrmsSum[17]) || voltageRms == 16'($past(vrmsRaw) + 16'($past(vrmsOffset))));
  endproperty
  a_vrmsOffset: assert property (p_vrmsOffset) else $error("rms offset not added");

  property p_offsetWidth;
    (wrSel && wrAddr == `OFS_VOLTAGE_RMS_OS) |=> vrmsOffset == $past(hwdata[11:0]);
  endproperty
  a_offsetWidth: assert property (p_offsetWidth) else $error("offset width wrong");

  property p_irmsRoot;
    resultStb |-> ({16'h0, currentRms} * {16'h0, currentRms}) <= $past(irmsSqCorr) &&
      (({17'h0, currentRms} + 33'h1) * ({17'h0, currentRms} + 33'h1)) >
      {1'b0, $past(irmsSqCorr)};
  endproperty
  a_irmsRoot: assert property (p_irmsRoot) else $error("current root exceeds sum");

  property p_apparentScale;
    lineDone |=> lineApparent == $past(appScaled);
  endproperty
  a_apparentScale: assert property (p_apparentScale) else $error("apparent not scaled");

  property p_reactiveOnlyLine;
    $changed(lineReactive) |-> $past(lineDone);
  endproperty
  a_reactiveOnlyLine: assert property (p_reactiveOnlyLine) else $error("reactive outside line mode");

  property p_varFilter;
    tickD1 |=> varAcc == $past(next_varAcc);
  endproperty
  a_varFilter: assert property (p_varFilter) else $error("reactive filter stalled");

  sequence s_lineLatch;
    lineDone ##1 (lineActive == $past(accAct) && status[`ST_LINE]);
  endsequence
  property p_lineTogether;
    lineDone |-> s_lineLatch;
  endproperty
  a_lineTogether: assert property (p_lineTogether) else $error("line results not together");

  property p_phaseZero;
    (phaseAdjust == `PHASE_ZERO) |-> vTap == `CURRENT_TAP;
  endproperty
  a_phaseZero: assert property (p_phaseZero) else $error("trim 0x0D not neutral");

  sequence s_zxSeen;
    zxEvent && ctrl[`CTRL_ZX_IRQ] && !wrSel;
  endsequence
  property p_zxIrq;
    s_zxSeen |-> ##2 irqOe;
  endproperty
  a_zxIrq: assert property (p_zxIrq) else $error("zero crossing not on pin");
endmodule

// file: include/rms_energy_cfg.svh
// Offsets, field positions, reset values and timing counts of the rms/energy datapath.
// Assumes a 25 MHz system clock and byte addresses taken from haddr[7:0].
`ifndef RMS_ENERGY_CFG_SVH
`define RMS_ENERGY_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_VOLTAGE_RMS_OS 8'h04
`define OFS_CURRENT_RMS_OS 8'h08
`define OFS_APP_GAIN 8'h0C
`define OFS_APP_DIV 8'h10
`define OFS_HALF_CYC 8'h14
`define OFS_PHASE 8'h18
`define OFS_VOLTAGE_RMS 8'h1C
`define OFS_CURRENT_RMS 8'h20
`define OFS_LINE_ACT 8'h24
`define OFS_LINE_APP 8'h28
`define OFS_LINE_REACT 8'h2C
`define OFS_STATUS 8'h30

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_LINE_EN 0
`define CTRL_ZX_IRQ 1
`define CTRL_LINE_IRQ 2
`define ST_LINE 0
`define ST_ZX 1
`define PHASE_RST 6'h0D
`define PHASE_ZERO 6'h0D
`define HALF_CYC_RST 16'h0064
`define APP_DIV_RST 8'h00

// ----------------------------------------
// Timing and arithmetic constants
// ----------------------------------------
`define MCLK_HZ 25000000
`define TICK_LAST 3'h7
`define CURRENT_TAP 6'h0D
`define SQ_LPF_SHIFT 8
`define VAR_CORNER_HZ 2
`define VAR_LPF_SHIFT 18
`define CURRENT_RMS_OS_SHIFT 15
`define GAIN_SHIFT 12
`define GAIN_ONE 13'h1000

`endif

// file: include/rms_energy_pkg.sv
// Types shared by the rms/energy datapath files.
// Assumes nothing of its surroundings.
package rms_energy_pkg;
  typedef logic signed [15:0] sample_type;
  typedef logic [31:0] word_type;
  typedef enum logic [0:0] {LINE_IDLE, LINE_RUN} line_state_type;
endpackage

// file: src/sample_delay_ram.sv
// Circular sample store with a programmable read tap and a registered read.
// Assumes writes come one per sample tick and the tap is steady between ticks.
`timescale 1ns/1ps
module sample_delay_ram
  import rms_energy_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstN,
  // Sample side
  input wire logic wrEn,
  input wire sample_type wrData,
  input wire logic [5:0] tap,
  output sample_type rdData
);
  sample_type mem [0:63];
  logic [5:0] ptr;
  wire [5:0] rdAddr = ptr - tap - 6'h01;

  // Write pointer and registered read, both once per tick
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      ptr <= 6'h00;
      rdData <= 16'sh0000;
    end else if (wrEn) begin
      ptr <= ptr + 6'h01;
      rdData <= mem[rdAddr];
    end
  end

  // Array needs no reset; stale entries only matter for the first 64 ticks
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[ptr] <= wrData;
    end
  end

  property p_tapZero;
    @(posedge sys_clk) disable iff (!rstN)
      (wrEn && tap == 6'h00 && $past(wrEn, 8)) |=> rdData == $past(wrData, 9);
  endproperty
  a_tapZero: assert property (p_tapZero) else $error("tap zero delay wrong");
endmodule

// file: bench/ahb_host.sv
// Host controller model: single-word AHB-Lite master plus interrupt pin watcher.
// Assumes the one slave's hreadyout is hready and the pin has a pull-up.
`timescale 1ns/1ps
`include "rms_energy_cfg.svh"
module ahb_host
  import rms_energy_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Bus requests
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Bus answers
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Interrupt pin, low when asserted
  input wire logic irqN
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One whole-word transfer; no wait length assumed, the bench watchdog cuts hangs.
  // Released lines show inverted data so stale values never look valid.
  task automatic xfer(input logic [7:0] a, input logic w, input word_type wd,
                      output word_type rd, output logic rs);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwdata <= ~hwdata;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    rs = hresp;
  endtask

  task automatic read_at_zx(input logic [7:0] a, output word_type rd);
    logic rs;
    while (irqN !== 1'b0) @(posedge sys_clk);
    xfer(a, 1'b0, 32'h0, rd, rs);
  endtask

  task automatic line_results(output word_type act, output word_type app,
                              output word_type re);
    logic rs;
    while (irqN !== 1'b0) @(posedge sys_clk);
    xfer(`OFS_LINE_ACT, 1'b0, 32'h0, act, rs);
    xfer(`OFS_LINE_APP, 1'b0, 32'h0, app, rs);
    xfer(`OFS_LINE_REACT, 1'b0, 32'h0, re, rs);
  endtask

  function automatic longint var_corrected(input word_type raw, input int calPer, input int per);
    return longint'($signed(raw)) * calPer / per;
  endfunction
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the rms/energy correction datapath.
// Assumes the host model as bus master; expectations come from an integer model.
`timescale 1ns/1ps
`include "rms_energy_cfg.svh"
module tb_top
  import rms_energy_pkg::*;
  ;
  logic sys_clk;
  logic rst_n;
  sample_type vSample;
  sample_type iSample;
  logic hsel;
  logic hwrite;
  logic hreadyout;
  logic hresp;
  logic irqOut;
  logic irqOe;
  logic irqN;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] cyc;
  int errors;
  int num_checks;
  int seed;

  // Open-drain pin with pull-up
  assign irqN = irqOe ? irqOut : 1'b1;

  rms_energy_correction_datapath rms_energy_correction_datapath_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .vSample(vSample), .iSample(iSample),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .irqOut(irqOut), .irqOe(irqOe));

  ahb_host ahb_host_i (
    .sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .irqN(irqN));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Cycle count keeps sample edges aligned to the design's tick grid
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= 32'h0;
    end else begin
      cyc <= cyc + 32'h1;
    end
  end

  task automatic check(input string nm, input word_type seen, input word_type exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input word_type d);
    word_type r;
    logic s;
    ahb_host_i.xfer(a, 1'b1, d, r, s);
  endtask

  task automatic rd(input logic [7:0] a, output word_type v);
    logic s;
    ahb_host_i.xfer(a, 1'b0, 32'h0, v, s);
  endtask

  // Integer root, floor; negatives clamp to zero
  function automatic int isqrt(input longint x);
    int r;
    r = 0;
    while (longint'(r + 1) * (r + 1) <= x) r++;
    return r;
  endfunction

  // Cycles from an aligned voltage sign flip to the zero-crossing interrupt
  task automatic measure(input logic [5:0] ph, output int d);
    sample_type mag;
    mag = sample_type'(($random(seed) & 32'h3FFF) + 1);
    vSample <= mag;
    wr(`OFS_PHASE, {26'h0, ph});
    wr(`OFS_CTRL, 32'h2);
    repeat (300) @(posedge sys_clk);
    wr(`OFS_STATUS, 32'h3);
    repeat (4) @(posedge sys_clk);
    do @(posedge sys_clk); while (cyc[2:0] != 3'h0);
    vSample <= -mag;
    d = 0;
    while (irqOe !== 1'b1 && d < 600) begin
      @(posedge sys_clk);
      d++;
    end
  endtask

  task automatic toggle(input int n);
    repeat (n) begin
      vSample <= -vSample;
      repeat (200) @(posedge sys_clk);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog, well past the expected few thousand cycles
  initial begin
    #800000;
    errors++;
    end_sim();
  end

  initial begin
    word_type v;
    word_type a;
    word_type b;
    word_type c;
    word_type offs[$];
    logic [5:0] phs[$];
    int sv;
    int d0;
    int d;
    errors = 0;
    num_checks = 0;
    seed = 32'hA8136DD2;
    offs = '{32'h0000_0002, 32'hFFFF_F800, 32'h0000_1020, 32'h0000_0080,
             32'h0000_0200, 32'h0000_0FFF};
    phs = '{6'h0D, 6'h0F, 6'h0B, 6'h00};
    rst_n = 1'b0;
    vSample = 16'sh0;
    iSample = 16'sh0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Reset values, read-only and unmapped places
    rd(`OFS_HALF_CYC, v);
    check("half_cycle_count", v, 32'h0000_0064);
    rd(`OFS_PHASE, v);
    check("phase_adjust", v, 32'h0000_000D);
    wr(`OFS_VOLTAGE_RMS, 32'h0000_1234);
    rd(`OFS_VOLTAGE_RMS, v);
    check("voltage_rms", v, 32'h0);
    rd(8'h40, v);
    check("unmapped", v, 32'h0);
    wr(`OFS_APP_GAIN, 32'hFFFF_FABC);
    rd(`OFS_APP_GAIN, v);
    check("apparent_gain", v, 32'h0000_0ABC);
    wr(`OFS_APP_DIV, 32'hFFFF_FABC);
    rd(`OFS_APP_DIV, v);
    check("apparent_divider", v, 32'h0000_00BC);
    // Offset corrections on silent channels
    foreach (offs[k]) begin
      wr(`OFS_VOLTAGE_RMS_OS, offs[k]);
      wr(`OFS_CURRENT_RMS_OS, offs[k]);
      repeat (40) @(posedge sys_clk);
      sv = $signed(offs[k][11:0]);
      rd(`OFS_VOLTAGE_RMS_OS, v);
      check("voltage_rms_offset", v, {20'h0, offs[k][11:0]});
      rd(`OFS_VOLTAGE_RMS, v);
      check("voltage_rms", v, (sv < 0) ? 32'h0 : 32'(sv));
      rd(`OFS_CURRENT_RMS, v);
      check("current_rms", v, 32'(isqrt(longint'(sv) * 32768)));
    end
    wr(`OFS_VOLTAGE_RMS_OS, 32'h0);
    wr(`OFS_CURRENT_RMS_OS, 32'h0);
    // Phase trim shifts the crossing by eight clocks a step
    measure(6'h0D, d0);
    foreach (phs[k]) begin
      measure(phs[k], d);
      check("voltage_delay", 32'(d - d0), 32'((int'(phs[k]) - 13) * 8));
    end
    // Crossings without line mode: no line result, masked pin
    wr(`OFS_HALF_CYC, 32'h2);
    wr(`OFS_CTRL, 32'h4);
    repeat (300) @(posedge sys_clk);
    wr(`OFS_STATUS, 32'h3);
    toggle(4);
    rd(`OFS_STATUS, v);
    check("status", v, 32'h2);
    check("irq_enable", {31'h0, irqOe}, 32'h0);
    // Line mode latches after two half cycles
    wr(`OFS_CTRL, 32'h5);
    toggle(6);
    ahb_host_i.line_results(a, b, c);
    check("line_active_energy", a, 32'h0);
    check("line_apparent_energy", b, 32'h0);
    check("line_reactive_energy", c, 32'h0);
    rd(`OFS_STATUS, v);
    check("line_done", v & 32'h1, 32'h1);
    // Zero-crossing pin paces a register read; last trim written was 0x00
    wr(`OFS_CTRL, 32'h2);
    ahb_host_i.read_at_zx(`OFS_PHASE, v);
    check("phase_adjust", v, 32'h0);
    v = 32'(ahb_host_i.var_corrected(32'h0000_0100, 5, 4));
    check("var_corrected", v, 32'h0000_0140);
    end_sim();
  end
endmodule
